// ===== src/svdm_init_ctrl.sv
// Structured VDM initiator controller with APB registers and message port
`timescale 1ns/1ps
// Overview of operation
// - Object position one picks first mode
// - Unused object position sent as zero
// - Requests carry the Initiator command type
// - After BUSY wait before retrying the request
// - Complete only after our GoodCRC is sent; Attention completes on the partner's GoodCRC
// - Initiator is whoever sends the request
// - NAK advises not to retry
// - No soft reset on missing cable GoodCRC
// - Cable discovery repeats on interval, bounded count
// - Identity request uses the standard SID
// - Identity request has one data object
// - Surplus identity objects are dropped quietly
// - Command type codes 00, 01, 10, 11
// - Command codes one to six, rest reserved; 16 to 31 also accepted as SVID-specific
// - Position 111b exits all, 000b reserved
module svdm_init_ctrl
  import svdm_pkg::*;
#(
  parameter int BUSY_CYC = SVDM_BUSY_CYC,
  parameter int DISC_CYC = SVDM_DISC_CYC,
  parameter int DISC_TRIES = SVDM_DISC_TRIES
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_prime,
  output logic [2:0] tx_ndo,
  output logic [31:0] tx_hdr,
  input wire logic tx_crc_ok,
  input wire logic tx_crc_fail,
  input wire logic rx_valid,
  input wire logic [31:0] rx_hdr,
  input wire logic [2:0] rx_ndo,
  input wire logic [31:0] rx_vdo,
  input wire logic [2:0] rx_vdo_idx,
  input wire logic rx_vdo_valid,
  input wire logic rx_goodcrc_sent,
  output logic mode_change
);
  // Refuse timing values that the counters cannot serve
  if (BUSY_CYC < 1 || DISC_CYC < 1 || DISC_TRIES < 1 || DISC_TRIES > 255) begin : g_bad_param
    $error("svdm_init_ctrl: bad timing parameter");
  end

  typedef enum logic [2:0] {S_IDLE, S_SEND, S_WCRC, S_WRESP, S_WDONE, S_BUSYW,
                            S_DISCW} svdm_st_t;

  typedef struct packed {
    svdm_st_t st;
    logic [31:0] hdr;
    logic prime;
    logic discover;
    logic [1:0] last_ct;
    logic done;
    logic err;
    logic nocable;
    logic [2:0] rx_cnt;
    logic [31:0] busy_cnt;
    logic [31:0] busy_lim;
    logic [31:0] disc_cnt;
    logic [7:0] tries;
    logic [SVDM_VDO_SLOTS*32-1:0] vdo;
    logic chg;
    logic [31:0] rdata;
  } svdm_state_t;

  svdm_state_t cur_ff, nxt_ff;
  logic rsp_hit;
  logic [1:0] rsp_ct;
  logic [2:0] rsp_keep;
  logic wr_go, apb_acc;

  // ---------------------------------------------------------------------------
  // Response decoder
  // ---------------------------------------------------------------------------
  svdm_rx_parse u_parse (
    .hdr(rx_hdr),
    .exp_cmd(cur_ff.hdr[SVDM_CMD_LSB +: 5]),
    .ndo(rx_ndo),
    .is_resp(rsp_hit),
    .ctype(rsp_ct),
    .keep_do(rsp_keep)
  );

  // Build a request header: command type forced to Initiator
  function automatic logic [31:0] mk_hdr(input logic [31:0] w);
    logic [4:0] cmd;
    logic [2:0] pos;
    logic [15:0] svid;
    cmd = w[SVDM_CMD_LSB +: 5];
    pos = w[SVDM_OBJPOS_LSB +: 3]; // index into the mode list as given
    svid = w[SVDM_SVID_LSB +: 16];
    if (cmd == SVDM_CMD_DISC_ID) begin
      svid = SVDM_PD_SID;
    end
    if (cmd != SVDM_CMD_ENTER && cmd != SVDM_CMD_EXIT && cmd != SVDM_CMD_ATTN) begin
      pos = 3'h0;
    end else if (cmd == SVDM_CMD_ENTER && pos == SVDM_POS_ALL) begin
      pos = 3'h0;
    end
    mk_hdr = {svid, 1'b1, 2'h0, 2'h0, pos, SVDM_CT_INIT, 1'b0, cmd};
  endfunction

  // Command code is one of the six defined ones or SVID-specific
  function automatic logic cmd_ok(input logic [4:0] c);
    cmd_ok = (c >= SVDM_CMD_DISC_ID && c <= SVDM_CMD_ATTN) || c[4];
  endfunction

  assign apb_acc = psel && penable;
  assign wr_go = apb_acc && pwrite && (paddr == SVDM_REG_CTRL) && pwdata[SVDM_CTL_GO];
  assign pready = 1'b1;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.chg = 1'b0;
    // APB writes
    if (apb_acc && pwrite) begin
      if (paddr == SVDM_REG_BUSYW) begin
        nxt_ff.busy_lim = (pwdata == 32'h0) ? 32'h1 : pwdata;
      end else if (paddr == SVDM_REG_STAT) begin
        nxt_ff.done = cur_ff.done & ~pwdata[0];
        nxt_ff.err = cur_ff.err & ~pwdata[1];
        nxt_ff.nocable = cur_ff.nocable & ~pwdata[2];
      end
    end
    case (cur_ff.st)
      S_IDLE: begin
        if (wr_go && cmd_ok(pwdata[4:0])) begin
          nxt_ff.hdr = mk_hdr(pwdata);
          nxt_ff.prime = pwdata[SVDM_CTL_PRIME];
          nxt_ff.discover = apb_acc && (paddr == SVDM_REG_CTRL) && pwdata[29]
                            && pwdata[4:0] == SVDM_CMD_DISC_ID;
          nxt_ff.tries = 8'h0;
          nxt_ff.done = 1'b0;
          nxt_ff.err = 1'b0;
          nxt_ff.st = S_SEND;
        end else if (wr_go) begin
          nxt_ff.err = 1'b1;
        end
      end
      S_SEND: begin
        if (tx_ready) begin
          nxt_ff.st = S_WCRC;
        end
      end
      S_WCRC: begin
        if (tx_crc_ok) begin
          // Attention expects no response
          nxt_ff.st = (cur_ff.hdr[4:0] == SVDM_CMD_ATTN) ? S_IDLE : S_WRESP;
          nxt_ff.done = (cur_ff.hdr[4:0] == SVDM_CMD_ATTN) | cur_ff.done;
          nxt_ff.rx_cnt = 3'h0;
        end else if (tx_crc_fail) begin
          if (cur_ff.prime && cur_ff.hdr[4:0] == SVDM_CMD_DISC_ID) begin
            // No soft reset; flag a possibly non-capable cable
            nxt_ff.nocable = 1'b1;
            if (cur_ff.discover && cur_ff.tries < 8'(DISC_TRIES - 1)) begin
              nxt_ff.tries = cur_ff.tries + 8'h1;
              nxt_ff.disc_cnt = 32'h0;
              nxt_ff.st = S_DISCW;
            end else begin
              nxt_ff.st = S_IDLE;
            end
          end else begin
            nxt_ff.err = 1'b1;
            nxt_ff.st = S_IDLE;
          end
        end
      end
      S_WRESP: begin
        if (rx_valid && rsp_hit) begin
          nxt_ff.last_ct = rsp_ct;
          nxt_ff.rx_cnt = rsp_keep;
          nxt_ff.st = S_WDONE;
        end
        if (rx_vdo_valid && rx_vdo_idx < SVDM_NDO_MAX) begin
          nxt_ff.vdo[32*rx_vdo_idx +: 32] = rx_vdo;
        end
      end
      S_WDONE: begin
        // Completion only once our GoodCRC for the response is out
        if (rx_goodcrc_sent) begin
          if (cur_ff.last_ct == SVDM_CT_BUSY) begin
            nxt_ff.busy_cnt = 32'h0;
            nxt_ff.st = S_BUSYW;
          end else begin
            nxt_ff.done = 1'b1;
            nxt_ff.err = (cur_ff.last_ct == SVDM_CT_NAK);
            nxt_ff.chg = (cur_ff.last_ct == SVDM_CT_ACK)
                         && (cur_ff.hdr[4:0] == SVDM_CMD_ENTER
                             || cur_ff.hdr[4:0] == SVDM_CMD_EXIT);
            nxt_ff.st = S_IDLE;
          end
        end
      end
      S_BUSYW: begin
        nxt_ff.busy_cnt = cur_ff.busy_cnt + 32'h1;
        if (cur_ff.busy_cnt + 32'h1 >= cur_ff.busy_lim) begin
          nxt_ff.st = S_SEND;
        end
      end
      S_DISCW: begin
        nxt_ff.disc_cnt = cur_ff.disc_cnt + 32'h1;
        if (cur_ff.disc_cnt + 32'h1 >= 32'(DISC_CYC)) begin
          nxt_ff.st = S_SEND;
        end
      end
      default: nxt_ff.st = S_IDLE;
    endcase
    // Read mux
    if (paddr == SVDM_REG_CTRL) begin
      nxt_ff.rdata = cur_ff.hdr;
    end else if (paddr == SVDM_REG_STAT) begin
      nxt_ff.rdata = {21'h0, cur_ff.tries[7:0], cur_ff.nocable, cur_ff.err, cur_ff.done};
      nxt_ff.rdata[31] = (cur_ff.st != S_IDLE);
    end else if (paddr == SVDM_REG_RESP) begin
      nxt_ff.rdata = {27'h0, cur_ff.rx_cnt, cur_ff.last_ct};
    end else if (paddr == SVDM_REG_BUSYW) begin
      nxt_ff.rdata = cur_ff.busy_lim;
    end else if (paddr == SVDM_REG_DISC) begin
      nxt_ff.rdata = 32'(DISC_TRIES);
    end else if (paddr >= SVDM_REG_VDO0 && paddr < SVDM_REG_VDO0 + 8'h1c) begin
      nxt_ff.rdata = cur_ff.vdo[32*(paddr[4:2]) +: 32];
    end else begin
      nxt_ff.rdata = 32'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
      cur_ff.busy_lim <= 32'(BUSY_CYC);
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Read data is registered in the setup cycle and stands through the access cycle
  always_comb begin
    prdata = cur_ff.rdata;
  end
  assign pslverr = 1'b0;
  assign tx_valid = (cur_ff.st == S_SEND); // this block is always the initiator
  assign tx_hdr = cur_ff.hdr;
  assign tx_prime = cur_ff.prime;
  assign tx_ndo = SVDM_NDO_HDR;
  assign mode_change = cur_ff.chg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_init_type;
    @(posedge pclk) disable iff (!presetn)
      tx_valid |-> tx_hdr[SVDM_CTYPE_LSB +: 2] == SVDM_CT_INIT;
  endproperty
  a_init_type: assert property (p_init_type) else $error("request not Initiator");

  property p_zero_pos;
    @(posedge pclk) disable iff (!presetn)
      (tx_valid && tx_hdr[4:0] < SVDM_CMD_ENTER) |-> tx_hdr[10:8] == 3'h0;
  endproperty
  a_zero_pos: assert property (p_zero_pos) else $error("unused position nonzero");

  property p_sid;
    @(posedge pclk) disable iff (!presetn)
      (tx_valid && tx_hdr[4:0] == SVDM_CMD_DISC_ID) |-> tx_hdr[31:16] == SVDM_PD_SID;
  endproperty
  a_sid: assert property (p_sid) else $error("identity SVID wrong");

  property p_ndo;
    @(posedge pclk) disable iff (!presetn)
      tx_valid |-> tx_ndo == 3'h1;
  endproperty
  a_ndo: assert property (p_ndo) else $error("request object count wrong");

  property p_busy_hold;
    @(posedge pclk) disable iff (!presetn)
      (cur_ff.st == S_WDONE && rx_goodcrc_sent && cur_ff.last_ct == SVDM_CT_BUSY)
        |=> !tx_valid [*1] ##0 (cur_ff.st == S_BUSYW);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("retry before wait");

  property p_done_crc;
    @(posedge pclk) disable iff (!presetn)
      $rose(mode_change) |-> $past(rx_goodcrc_sent);
  endproperty
  a_done_crc: assert property (p_done_crc) else $error("change before GoodCRC");

  property p_no_exit_all_enter;
    @(posedge pclk) disable iff (!presetn)
      (tx_valid && tx_hdr[4:0] == SVDM_CMD_ENTER) |-> tx_hdr[10:8] != 3'h7;
  endproperty
  a_no_exit_all_enter: assert property (p_no_exit_all_enter) else $error("111b on enter");

  property p_cable;
    @(posedge pclk) disable iff (!presetn)
      (cur_ff.st == S_WCRC && tx_crc_fail && cur_ff.prime && cur_ff.hdr[4:0] == 5'h01)
        |=> cur_ff.nocable;
  endproperty
  a_cable: assert property (p_cable) else $error("cable flag not set");
endmodule

// ===== src/svdm_pkg.sv
// Package of constants for the structured VDM initiator controller
package svdm_pkg;
  // ---------------------------------------------------------------------------
  // Header field positions and encodings
  // ---------------------------------------------------------------------------
  localparam int SVDM_SVID_LSB = 16;
  localparam int SVDM_TYPE_BIT = 15;
  localparam int SVDM_OBJPOS_LSB = 8;
  localparam int SVDM_CTYPE_LSB = 6;
  localparam int SVDM_CMD_LSB = 0;
  localparam logic [15:0] SVDM_PD_SID = 16'hff00;
  localparam logic [1:0] SVDM_CT_INIT = 2'h0;
  localparam logic [1:0] SVDM_CT_ACK = 2'h1;
  localparam logic [1:0] SVDM_CT_NAK = 2'h2;
  localparam logic [1:0] SVDM_CT_BUSY = 2'h3;
  localparam logic [4:0] SVDM_CMD_DISC_ID = 5'h01;
  localparam logic [4:0] SVDM_CMD_DISC_SVID = 5'h02;
  localparam logic [4:0] SVDM_CMD_DISC_MODE = 5'h03;
  localparam logic [4:0] SVDM_CMD_ENTER = 5'h04;
  localparam logic [4:0] SVDM_CMD_EXIT = 5'h05;
  localparam logic [4:0] SVDM_CMD_ATTN = 5'h06;
  localparam logic [2:0] SVDM_POS_ALL = 3'h7;
  localparam logic [2:0] SVDM_MAX_MODES = 3'h6;
  localparam logic [2:0] SVDM_NDO_HDR = 3'h1;
  localparam logic [2:0] SVDM_NDO_MAX = 3'h7;
  // ---------------------------------------------------------------------------
  // Software register map (byte offsets)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SVDM_REG_CTRL = 8'h00;
  localparam logic [7:0] SVDM_REG_STAT = 8'h04;
  localparam logic [7:0] SVDM_REG_RESP = 8'h08;
  localparam logic [7:0] SVDM_REG_BUSYW = 8'h0c;
  localparam logic [7:0] SVDM_REG_DISC = 8'h10;
  localparam logic [7:0] SVDM_REG_VDO0 = 8'h20;
  localparam int SVDM_VDO_SLOTS = 7;
  // Control word fields
  localparam int SVDM_CTL_GO = 31;
  localparam int SVDM_CTL_PRIME = 30;
  // ---------------------------------------------------------------------------
  // Timing defaults
  // ---------------------------------------------------------------------------
  localparam int SVDM_CLK_HZ = 20000000;
  localparam int SVDM_BUSY_US = 50;
  localparam int SVDM_BUSY_CYC = SVDM_BUSY_US * (SVDM_CLK_HZ / 1000000);
  localparam int SVDM_DISC_MS = 45;
  localparam int SVDM_DISC_CYC = SVDM_DISC_MS * (SVDM_CLK_HZ / 1000);
  localparam int SVDM_DISC_TRIES = 20;
endpackage

// ===== src/svdm_rx_parse.sv
// Response header decoder for the structured VDM initiator
`timescale 1ns/1ps
module svdm_rx_parse
  import svdm_pkg::*;
(
  input wire logic [31:0] hdr,
  input wire logic [4:0] exp_cmd,
  input wire logic [2:0] ndo,
  output logic is_resp,
  output logic [1:0] ctype,
  output logic [2:0] keep_do
);
  // ---------------------------------------------------------------------------
  // Match a response to the outstanding command
  // ---------------------------------------------------------------------------
  always_comb begin
    ctype = hdr[SVDM_CTYPE_LSB +: 2];
    is_resp = hdr[SVDM_TYPE_BIT] && (hdr[SVDM_CMD_LSB +: 5] == exp_cmd)
              && (ctype != SVDM_CT_INIT);
    // Surplus objects beyond the stored slots are dropped silently
    keep_do = (ndo > SVDM_NDO_MAX) ? SVDM_NDO_MAX : ndo;
  end
endmodule

// ===== dv/svdm_resp_model.sv
// Responder model of the remote port or cable plug on the message port
`timescale 1ns/1ps
module svdm_resp_model
  import svdm_pkg::*;
(
  input wire logic pclk,
  input wire logic tx_valid,
  input wire logic tx_prime,
  input wire logic [31:0] tx_hdr,
  output logic tx_ready,
  output logic tx_crc_ok,
  output logic tx_crc_fail,
  output logic rx_valid,
  output logic [31:0] rx_hdr,
  output logic [2:0] rx_ndo,
  output logic [31:0] rx_vdo,
  output logic [2:0] rx_vdo_idx,
  output logic rx_vdo_valid,
  output logic rx_goodcrc_sent,
  input wire logic [3:0] busy_n,
  input wire logic no_cable
);
  localparam int NMODES = 2;
  logic [7:0] act;
  logic [1:0] ct;
  logic [2:0] n;
  logic [4:0] cmd;
  logic [2:0] pos;
  int used;
  // Accept, GoodCRC, answer, then pulse rx_goodcrc_sent for the initiator GoodCRC
  initial begin
    {tx_ready, tx_crc_ok, tx_crc_fail, rx_valid, rx_vdo_valid, rx_goodcrc_sent} = '0;
    {rx_hdr, rx_ndo, rx_vdo, rx_vdo_idx, act} = '0;
    used = 0;
    forever begin
      @(posedge pclk);
      if (tx_valid) begin // answers only as responder
        tx_ready <= 1'b1;
        @(posedge pclk);
        tx_ready <= 1'b0;
        cmd = tx_hdr[4:0];
        pos = tx_hdr[10:8];
        @(posedge pclk);
        if (no_cable && tx_prime) begin
          tx_crc_fail <= 1'b1;
          @(posedge pclk);
          tx_crc_fail <= 1'b0;
        end else begin
          tx_crc_ok <= 1'b1;
          @(posedge pclk);
          tx_crc_ok <= 1'b0;
          ct = SVDM_CT_NAK; // unknown commands
          n = 3'h0;
          if (used < busy_n && cmd != 0 && cmd <= SVDM_CMD_DISC_MODE) begin
            ct = SVDM_CT_BUSY;
            used++;
          end else if (cmd == SVDM_CMD_DISC_ID) begin
            ct = SVDM_CT_ACK; // no product-type object
            n = 3'h3;
          end else if (cmd == SVDM_CMD_DISC_SVID) begin
            ct = SVDM_CT_ACK;
            n = 3'h1;
          end else if (cmd == SVDM_CMD_DISC_MODE) begin
            ct = SVDM_CT_ACK;
            n = 3'(NMODES);
          end else if (cmd == SVDM_CMD_ENTER && pos != 0 && pos <= NMODES) begin
            ct = SVDM_CT_ACK;
            act[pos] = 1'b1;
          end else if (cmd == SVDM_CMD_EXIT && pos == SVDM_POS_ALL) begin
            ct = SVDM_CT_ACK;
            act = '0;
          end else if (cmd == SVDM_CMD_EXIT && pos != 0 && pos <= NMODES && act[pos]) begin
            ct = SVDM_CT_ACK; // inactive modes are refused
            act[pos] = 1'b0;
          end
          if (ct != SVDM_CT_BUSY) used = 0;
          if (cmd != SVDM_CMD_ATTN) begin // no answer to Attention
            for (int i = 0; i < n; i++) begin
              @(posedge pclk);
              rx_vdo <= {16'h0a0b, 16'(i)};
              rx_vdo_idx <= 3'(i);
              rx_vdo_valid <= 1'b1;
            end
            @(posedge pclk);
            rx_vdo_valid <= 1'b0;
            rx_vdo <= ~rx_vdo;
            rx_hdr <= {tx_hdr[31:8], ct, tx_hdr[5:0]};
            rx_ndo <= n + 3'h1;
            rx_valid <= 1'b1;
            @(posedge pclk);
            rx_valid <= 1'b0;
            rx_hdr <= ~rx_hdr;
            @(posedge pclk);
            rx_goodcrc_sent <= 1'b1;
            @(posedge pclk);
            rx_goodcrc_sent <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// ===== dv/structured_vdm_command_handler_test.sv
// Self-checking bench for the structured VDM initiator controller
`timescale 1ns/1ps
module structured_vdm_command_handler_test;
  import svdm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tv_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, tx_hdr, rx_hdr, rx_vdo, rd;
  logic tx_valid, tx_ready, tx_prime, tx_crc_ok, tx_crc_fail, rx_valid, rx_vdo_valid;
  logic rx_goodcrc_sent, mode_change, no_cable;
  logic [2:0] tx_ndo, rx_ndo, rx_vdo_idx;
  logic [3:0] busy_n;
  int mismatches, samples_checked, cyc, t_busy, gap, mc_cnt, n_req, n0;
  logic [4:0] bad_cmd [3] = '{5'h0, 5'h7, 5'hf};
  svdm_init_ctrl #(.BUSY_CYC(4), .DISC_CYC(16), .DISC_TRIES(3)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_prime(tx_prime), .tx_ndo(tx_ndo),
    .tx_hdr(tx_hdr), .tx_crc_ok(tx_crc_ok), .tx_crc_fail(tx_crc_fail), .rx_valid(rx_valid),
    .rx_hdr(rx_hdr), .rx_ndo(rx_ndo), .rx_vdo(rx_vdo), .rx_vdo_idx(rx_vdo_idx),
    .rx_vdo_valid(rx_vdo_valid), .rx_goodcrc_sent(rx_goodcrc_sent), .mode_change(mode_change));
  svdm_resp_model far (.pclk(pclk), .tx_valid(tx_valid), .tx_prime(tx_prime), .tx_hdr(tx_hdr),
    .tx_ready(tx_ready), .tx_crc_ok(tx_crc_ok), .tx_crc_fail(tx_crc_fail), .rx_valid(rx_valid),
    .rx_hdr(rx_hdr), .rx_ndo(rx_ndo), .rx_vdo(rx_vdo), .rx_vdo_idx(rx_vdo_idx),
    .rx_vdo_valid(rx_vdo_valid), .rx_goodcrc_sent(rx_goodcrc_sent), .busy_n(busy_n),
    .no_cable(no_cable));
  // ---------------------------------------------------------------------------
  // Clock, monitors and helpers
  // ---------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Cycle count, BUSY-to-resend gap and mode change pulses
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    tv_q <= tx_valid;
    if (rx_valid && rx_hdr[7:6] == SVDM_CT_BUSY) t_busy <= cyc;
    if (tx_valid && !tv_q && t_busy > 0) gap <= cyc - t_busy;
    if (mode_change === 1'b1) mc_cnt <= mc_cnt + 1;
    if (tx_valid && !tv_q) n_req <= n_req + 1;
  end
  task automatic summarize;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; read data is taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  function automatic logic [31:0] c(input logic [15:0] s, input logic [2:0] p, input logic [4:0] m);
    return {s, 5'h0, p, 3'h0, m};
  endfunction
  function automatic logic [31:0] h(input logic [15:0] s, input logic [2:0] p, input logic [4:0] m);
    return {s, 1'b1, 4'h0, p, SVDM_CT_INIT, 1'b0, m};
  endfunction
  // Issue one command, check the request, wait for status and the answer
  task automatic run(input logic [31:0] ctl, input logic [31:0] hdr, input logic err,
                     input logic [31:0] resp, input logic [31:0] rmask);
    apb(1'b1, SVDM_REG_CTRL, ctl);
    for (int i = 0; i < 50 && tx_valid !== 1'b1; i++) @(posedge pclk);
    chk("request header", tx_hdr, hdr);
    chk("request objects", {29'h0, tx_ndo}, 32'h1);
    chk("request target", {31'h0, tx_prime}, {31'h0, ctl[SVDM_CTL_PRIME]});
    rd = '0;
    for (int i = 0; i < 400 && rd[2:0] === 3'h0; i++) apb(1'b0, SVDM_REG_STAT, 32'h0);
    chk("error flag", {31'h0, rd[1]}, {31'h0, err});
    apb(1'b1, SVDM_REG_STAT, 32'h7);
    apb(1'b0, SVDM_REG_RESP, 32'h0);
    chk("response", rd & rmask, resp);
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, presetn, no_cable} = '0;
    {paddr, pwdata, busy_n} = '0;
    {mismatches, samples_checked} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc("status at reset", SVDM_REG_STAT, 32'h0);
    rdc("busy wait at reset", SVDM_REG_BUSYW, 32'h4);
    rdc("max tries", SVDM_REG_DISC, 32'h3);
    apb(1'b1, 8'h40, 32'hffff_ffff);
    rdc("unmapped", 8'h40, 32'h0);
    run(c(16'h8123, 0, SVDM_CMD_DISC_MODE), h(16'h8123, 0, SVDM_CMD_DISC_MODE), 0, 32'hd, 32'h1f);
    for (int i = 0; i < 2; i++) rdc("mode object", 8'(SVDM_REG_VDO0 + 4 * i), {16'h0a0b, 16'(i)});
    run(c(SVDM_PD_SID, 0, SVDM_CMD_DISC_ID), h(SVDM_PD_SID, 0, SVDM_CMD_DISC_ID), 0, 32'h11, 32'h1f);
    for (int i = 0; i < 3; i++) rdc("identity object", 8'(SVDM_REG_VDO0 + 4 * i), {16'h0a0b, 16'(i)});
    run(c(16'h8123, 1, SVDM_CMD_ENTER), h(16'h8123, 1, SVDM_CMD_ENTER), 0, 32'h5, 32'h1f);
    chk("mode pulse after enter", mc_cnt, 1);
    run(c(16'h8123, 2, SVDM_CMD_EXIT), h(16'h8123, 2, SVDM_CMD_EXIT), 1, 32'h2, 32'h3);
    chk("no pulse after refusal", mc_cnt, 1);
    run(c(16'h8123, 7, SVDM_CMD_EXIT), h(16'h8123, 7, SVDM_CMD_EXIT), 0, 32'h1, 32'h3);
    chk("mode pulse after exit all", mc_cnt, 2);
    apb(1'b1, SVDM_REG_BUSYW, 32'h0);
    rdc("zero busy wait", SVDM_REG_BUSYW, 32'h1);
    apb(1'b1, SVDM_REG_BUSYW, 32'h6);
    busy_n <= 4'h1;
    run(c(16'h8123, 0, SVDM_CMD_DISC_MODE), h(16'h8123, 0, SVDM_CMD_DISC_MODE), 0, 32'hd, 32'h1f);
    chk("busy retry wait", {31'h0, gap >= 6}, 32'h1);
    busy_n <= 4'h0;
    run(c(16'h8123, 1, SVDM_CMD_ATTN), h(16'h8123, 1, SVDM_CMD_ATTN), 0, 32'h0, 32'h0);
    foreach (bad_cmd[k]) begin
      apb(1'b1, SVDM_REG_CTRL, c(16'h8123, 0, bad_cmd[k]));
      repeat (20) @(posedge pclk);
      chk("no request sent", {31'h0, tx_valid}, 32'h0);
      rdc("bad command error", SVDM_REG_STAT, 32'h2);
      apb(1'b1, SVDM_REG_STAT, 32'h7);
    end
    no_cable <= 1'b1;
    n0 = n_req;
    apb(1'b1, SVDM_REG_CTRL, c(SVDM_PD_SID, 0, SVDM_CMD_DISC_ID));
    rd = '0;
    for (int i = 0; i < 600 && (rd[2] !== 1'b1 || rd[31] !== 1'b0); i++)
      apb(1'b0, SVDM_REG_STAT, 32'h0);
    chk("no cable flag", {31'h0, rd[2]}, 32'h1);
    chk("discovery retries", {24'h0, rd[10:3]}, 32'h2);
    chk("discovery sends", n_req - n0, 32'h3);
    summarize();
  end
  // Watchdog against a hung handshake
  initial begin
    #2000000;
    mismatches++;
    summarize();
  end
endmodule
